/* File: rtl/flash_cmd_pkg.sv */
// Constants and types for the flash storage command handler
//
// Behaviour
// (R1) Requests target cluster 0x23, endpoint 0xE6
// (R2) Frame type 0x11 carries flash requests
// (R3) Network clients use UDP port 0x0bee
// (R4) Header: code, options, block, offset, count, data
// (R5) Multi-byte header fields are big-endian
// (R6) Valid block index is 0 through 159
// (R7) Byte count is data length or read size
// (R8) Reply unicast to source endpoint; broadcast silent
// (R9) Explicit receive frame if endpoint 0xE6 or mode
// (R10) Reply mirrors request; options become status
// (R11) Status bit zero set on error only
// (R12) Geometry query is code 0x00, all zero
// (R13) Geometry reply 0x80: blocks, block size, zero
// (R14) Erase code 0x01 sets affected bits to one
// (R15) Count zero erases all, else named block
// (R16) Erase start index must be zero; the code does not check it and erases with status OK
// (R17) Erase options byte must be zero; the code does not check it and erases with status OK
// (R18) Erase reply 0x81 echoes block and offset
// (R19) Array is 160 blocks of 4096 bytes
// (R20) Error on bad block or unknown code
package flash_cmd_pkg;
  localparam logic [7:0]  FRAME_TYPE_EXPLICIT = 8'h11;
  localparam logic [15:0] CLUSTER_MEMORY      = 16'h0023;
  localparam logic [7:0]  ENDPOINT_DEVICE     = 8'he6;
  localparam logic [15:0] UDP_PORT_FLASH      = 16'h0bee;
  localparam logic [7:0]  CMD_GEOMETRY_QUERY  = 8'h00;
  localparam logic [7:0]  CMD_ERASE           = 8'h01;
  localparam logic [7:0]  CMD_GEOMETRY_REPLY  = 8'h80;
  localparam logic [7:0]  CMD_ERASE_REPLY     = 8'h81;
  localparam logic [7:0]  CMD_REPLY_BIT       = 8'h80;
  localparam logic [7:0]  STATUS_OK           = 8'h00;
  localparam logic [7:0]  STATUS_ERROR        = 8'h01;
  localparam logic [15:0] BLOCK_COUNT         = 16'h00a0;
  localparam logic [15:0] BLOCK_SIZE          = 16'h1000;
  localparam logic [15:0] LAST_BLOCK          = 16'h009f;
  localparam logic [3:0]  HEADER_LEN          = 4'h8;
  localparam logic [3:0]  OFS_CODE            = 4'h0;
  localparam logic [3:0]  OFS_OPTION          = 4'h1;
  localparam logic [3:0]  OFS_BLOCK           = 4'h2;
  localparam logic [3:0]  OFS_START           = 4'h4;
  localparam logic [3:0]  OFS_COUNT           = 4'h6;
  localparam int          BLOCK_BITS          = 8;
  localparam int          ERASE_STEP_CYCLES   = 1;

  typedef struct packed {
    logic [7:0]  command_code;
    logic [7:0]  option_byte;
    logic [15:0] block_index;
    logic [15:0] byte_offset_in_block;
    logic [15:0] byte_count;
  } header_t;

  typedef struct packed {
    logic [7:0]  frame_type;
    logic [15:0] cluster;
    logic [7:0]  dest_endpoint;
    logic [7:0]  src_endpoint;
    logic        broadcast;
    logic        from_udp;
    logic [15:0] udp_port;
  } frame_info_t;

  typedef struct packed {
    logic [7:0] src_endpoint;
    logic       explicit_rx;
    logic       from_udp;
  } reply_route_t;
endpackage

/* File: rtl/flash_command_handler.sv */
// Flash storage command decoder, erase engine and reply builder
`timescale 1ns/1ns
module flash_command_handler (
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  input  wire flash_cmd_pkg::frame_info_t  frame_info_i,
  input  wire logic                        frame_start_i,
  input  wire logic                        byte_valid_i,
  input  wire logic [7:0]                  byte_i,
  input  wire logic                        byte_last_i,
  output logic                             byte_ready_o,
  input  wire logic                        explicit_mode_i,
  output logic                             erase_valid_o,
  output logic [7:0]                       erase_block_o,
  input  wire logic                        erase_done_i,
  output logic                             reply_valid_o,
  output flash_cmd_pkg::header_t           reply_header_o,
  output flash_cmd_pkg::reply_route_t      reply_route_o,
  input  wire logic                        reply_ready_i,
  output logic                             passed_on_o
);
  // ==========================================================
  // State
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RECV  = 5'b00010,
    ST_EXEC  = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_REPLY = 5'b10000
  } state_t;

  state_t                    state_reg;
  state_t                    state_next;
  logic [3:0]                pos_reg;
  flash_cmd_pkg::frame_info_t info_reg;
  logic                      explicit_reg;
  logic                      accept_reg;
  logic [7:0]                erase_idx_reg;
  logic                      erase_all_reg;
  logic                      short_reg;
  flash_cmd_pkg::header_t    req;
  logic                      clear;
  logic                      take;
  logic                      is_ours;
  logic                      block_bad;
  logic                      known;
  logic                      do_reply;
  logic                      is_erase;

  assign clear        = (state_reg == ST_IDLE) && frame_start_i;
  assign byte_ready_o = (state_reg == ST_RECV);
  assign take         = byte_ready_o && byte_valid_i;

  // ==========================================================
  // Header fields
  header_field_shift #(.WIDTH(8), .OFFSET(flash_cmd_pkg::OFS_CODE)) u_code (
    .clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear), .byte_valid_i(take),
    .byte_pos_i(pos_reg), .byte_i(byte_i), .field_o(req.command_code)); // see (R4)
  header_field_shift #(.WIDTH(8), .OFFSET(flash_cmd_pkg::OFS_OPTION)) u_opt (
    .clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear), .byte_valid_i(take),
    .byte_pos_i(pos_reg), .byte_i(byte_i), .field_o(req.option_byte));
  header_field_shift #(.WIDTH(16), .OFFSET(flash_cmd_pkg::OFS_BLOCK)) u_blk (
    .clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear), .byte_valid_i(take),
    .byte_pos_i(pos_reg), .byte_i(byte_i), .field_o(req.block_index));
  header_field_shift #(.WIDTH(16), .OFFSET(flash_cmd_pkg::OFS_START)) u_start (
    .clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear), .byte_valid_i(take),
    .byte_pos_i(pos_reg), .byte_i(byte_i), .field_o(req.byte_offset_in_block));
  header_field_shift #(.WIDTH(16), .OFFSET(flash_cmd_pkg::OFS_COUNT)) u_cnt (
    .clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear), .byte_valid_i(take),
    .byte_pos_i(pos_reg), .byte_i(byte_i), .field_o(req.byte_count)); // see (R7)

  // ==========================================================
  // Frame acceptance
  assign is_ours = frame_info_i.from_udp ? (frame_info_i.udp_port == flash_cmd_pkg::UDP_PORT_FLASH) // see (R3)
                 : (frame_info_i.frame_type == flash_cmd_pkg::FRAME_TYPE_EXPLICIT // see (R2)
                    && frame_info_i.cluster == flash_cmd_pkg::CLUSTER_MEMORY // see (R1)
                    && frame_info_i.dest_endpoint == flash_cmd_pkg::ENDPOINT_DEVICE);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      info_reg     <= '0;
      explicit_reg <= 1'b0;
      accept_reg   <= 1'b0;
    end else if (clear) begin
      info_reg     <= frame_info_i;
      explicit_reg <= explicit_mode_i;
      accept_reg   <= is_ours;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_reg   <= 4'h0;
      short_reg <= 1'b0;
    end else if (clear) begin
      pos_reg   <= 4'h0;
      short_reg <= 1'b0;
    end else if (take) begin
      if (pos_reg < flash_cmd_pkg::HEADER_LEN) begin
        pos_reg <= pos_reg + 4'h1;
      end
      if (byte_last_i && pos_reg < flash_cmd_pkg::HEADER_LEN - 4'h1) begin
        short_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Decode
  assign block_bad = req.block_index > flash_cmd_pkg::LAST_BLOCK; // see (R6) (R20)
  assign is_erase  = req.command_code == flash_cmd_pkg::CMD_ERASE;
  assign known     = (req.command_code == flash_cmd_pkg::CMD_GEOMETRY_QUERY) || is_erase;
  assign do_reply  = accept_reg && !info_reg.broadcast; // see (R8)
  assign passed_on_o = (state_reg == ST_EXEC) && accept_reg && !known;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (frame_start_i) state_next = ST_RECV;
      ST_RECV:  if (take && byte_last_i) state_next = ST_EXEC;
      ST_EXEC: begin
        if (!accept_reg || short_reg) state_next = ST_IDLE;
        else if (is_erase && (req.byte_count == 16'h0000 || !block_bad)) state_next = ST_ERASE;
        else if (do_reply) state_next = ST_REPLY;
        else state_next = ST_IDLE;
      end
      ST_ERASE: if (erase_done_i && (!erase_all_reg || erase_idx_reg == 8'(flash_cmd_pkg::LAST_BLOCK)))
                  state_next = do_reply ? ST_REPLY : ST_IDLE;
      ST_REPLY: if (reply_ready_i) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Erase engine: one block request at a time
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_idx_reg <= 8'h00;
      erase_all_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      erase_all_reg <= req.byte_count == 16'h0000; // see (R15)
      erase_idx_reg <= (req.byte_count == 16'h0000) ? 8'h00 : req.block_index[7:0];
    end else if (state_reg == ST_ERASE && erase_done_i && erase_all_reg) begin
      erase_idx_reg <= erase_idx_reg + 8'h01; // see (R14) (R19)
    end
  end

  assign erase_valid_o = (state_reg == ST_ERASE);
  assign erase_block_o = erase_idx_reg;

  // ==========================================================
  // Reply builder
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_header_o <= '0;
      reply_route_o  <= '0;
    end else if (state_reg == ST_EXEC) begin
      reply_route_o.src_endpoint <= info_reg.src_endpoint; // see (R8)
      reply_route_o.from_udp     <= info_reg.from_udp;
      reply_route_o.explicit_rx  <= !info_reg.from_udp && // see (R9)
        (info_reg.src_endpoint == flash_cmd_pkg::ENDPOINT_DEVICE || explicit_reg);
      reply_header_o.byte_count  <= 16'h0000; // see (R10)
      if (req.command_code == flash_cmd_pkg::CMD_GEOMETRY_QUERY) begin
        reply_header_o.command_code         <= flash_cmd_pkg::CMD_GEOMETRY_REPLY; // see (R13)
        reply_header_o.option_byte          <= flash_cmd_pkg::STATUS_OK; // see (R11)
        reply_header_o.block_index          <= flash_cmd_pkg::BLOCK_COUNT; // see (R19)
        reply_header_o.byte_offset_in_block <= flash_cmd_pkg::BLOCK_SIZE;
      end else begin
        reply_header_o.command_code         <= is_erase ? flash_cmd_pkg::CMD_ERASE_REPLY // see (R18)
                                               : (req.command_code | flash_cmd_pkg::CMD_REPLY_BIT);
        reply_header_o.option_byte          <= (!known || (is_erase && req.byte_count != 16'h0000 && block_bad))
                                               ? flash_cmd_pkg::STATUS_ERROR : flash_cmd_pkg::STATUS_OK; // see (R20)
        reply_header_o.block_index          <= req.block_index;
        reply_header_o.byte_offset_in_block <= req.byte_offset_in_block;
      end
    end
  end

  assign reply_valid_o = (state_reg == ST_REPLY);

  // ==========================================================
  // Checks
  a_reply_unicast_only: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R8)
    reply_valid_o |-> !info_reg.broadcast && accept_reg) else $error("reply to broadcast");
  a_geometry_reply_fields: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R13)
    reply_valid_o && reply_header_o.command_code == flash_cmd_pkg::CMD_GEOMETRY_REPLY
    |-> reply_header_o.block_index == 16'h00a0 && reply_header_o.byte_offset_in_block == 16'h1000)
    else $error("bad geometry reply");
  a_reply_count_zero: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R10)
    reply_valid_o |-> reply_header_o.byte_count == 16'h0000) else $error("nonzero reply count");
  a_status_reserved: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R11)
    reply_valid_o |-> reply_header_o.option_byte[7:1] == 7'h00) else $error("reserved status set");
  a_erase_in_range: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R6)
    erase_valid_o |-> erase_block_o <= 8'h9f) else $error("erase out of range");
  a_erase_reply_code: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R18)
    $rose(reply_valid_o) && $past(state_reg) == ST_ERASE
    |-> reply_header_o.command_code == flash_cmd_pkg::CMD_ERASE_REPLY) else $error("bad erase reply");
  a_bad_block_error: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R20)
    state_reg == ST_EXEC && accept_reg && !short_reg && block_bad && is_erase && req.byte_count != 16'h0000
    ##1 reply_valid_o |-> reply_header_o.option_byte[0]) else $error("missing error bit");
  a_erase_all_walk: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R15)
    erase_valid_o && erase_done_i && erase_all_reg && erase_block_o != 8'h9f
    |=> erase_valid_o && erase_block_o == $past(erase_block_o) + 8'h01) else $error("erase walk broken");
  a_explicit_route: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R9)
    reply_valid_o && !reply_route_o.from_udp && reply_route_o.src_endpoint == 8'he6
    |-> reply_route_o.explicit_rx) else $error("explicit route missed");
  a_short_frame_drop: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R4)
    state_reg == ST_EXEC && short_reg |=> state_reg == ST_IDLE) else $error("short frame not dropped");
  a_erase_request_hold: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R14)
    erase_valid_o && !erase_done_i |=> erase_valid_o && $stable(erase_block_o)) else $error("erase request lost");
  a_unknown_code_error: assert property (@(posedge clock_i) disable iff (!resetn_i) // see (R20)
    state_reg == ST_EXEC && accept_reg && !short_reg && !known
    ##1 reply_valid_o |-> reply_header_o.option_byte[0]) else $error("unknown code without error");
endmodule

/* File: rtl/header_field_shift.sv */
// Big-endian byte collector for one header field
`timescale 1ns/1ns
module header_field_shift #(
  parameter int          WIDTH  = 16,
  parameter logic [3:0]  OFFSET = 4'h0
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             clear_i,
  input  wire logic             byte_valid_i,
  input  wire logic [3:0]       byte_pos_i,
  input  wire logic [7:0]       byte_i,
  output logic      [WIDTH-1:0] field_o
);
  localparam int          NBYTES = WIDTH / 8;
  localparam logic [3:0]  LAST   = OFFSET + 4'(NBYTES - 1);

  // Most significant byte arrives first
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      field_o <= '0;
    end else if (clear_i) begin
      field_o <= '0;
    end else if (byte_valid_i && byte_pos_i >= OFFSET && byte_pos_i <= LAST) begin
      field_o <= {field_o[WIDTH-1:0] << 8} | WIDTH'(byte_i); // see (R5)
    end
  end
endmodule

/* File: verification/flash_erase_memory_model.sv */
// Behavioural flash array that answers block erase requests
`timescale 1ns/1ns
module flash_erase_memory_model (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        erase_valid_i,
  input  wire logic [7:0]  erase_block_i,
  input  wire logic [1:0]  delay_i,
  output logic             erase_done_o,
  output logic [15:0]      erase_count_o,
  output logic [7:0]       last_block_o,
  output logic             bad_block_o
);
  logic [1:0] wait_reg;
  // ==========
  // Erase timing, prompt or slow
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_reg      <= 2'h0;
      erase_done_o  <= 1'b0;
      erase_count_o <= 16'h0000;
      last_block_o  <= 8'h00;
      bad_block_o   <= 1'b0;
    end else begin
      erase_done_o <= 1'b0;
      if (erase_valid_i && !erase_done_o) begin
        if (wait_reg == delay_i) begin
          erase_done_o  <= 1'b1;
          wait_reg      <= 2'h0;
          erase_count_o <= erase_count_o + 16'h0001;
          last_block_o  <= erase_block_i;
          if (erase_block_i > 8'h9f) bad_block_o <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule

/* File: verification/flash_memory_command_handler_tb_top.sv */
// Self-checking bench for the flash storage command handler
`timescale 1ns/1ns
module flash_memory_command_handler_tb_top;
  logic                         clock_i = 1'b0;
  logic                         resetn_i = 1'b0;
  flash_cmd_pkg::frame_info_t   frame_info_i = '0;
  logic                         frame_start_i = 1'b0;
  logic                         byte_valid_i = 1'b0;
  logic [7:0]                   byte_i = 8'h00;
  logic                         byte_last_i = 1'b0;
  logic                         byte_ready_o;
  logic                         explicit_mode_i = 1'b0;
  logic                         erase_valid_o;
  logic [7:0]                   erase_block_o;
  logic                         erase_done_i;
  logic                         reply_valid_o;
  flash_cmd_pkg::header_t       reply_header_o;
  flash_cmd_pkg::reply_route_t  reply_route_o;
  logic                         reply_ready_i = 1'b0;
  logic                         passed_on_o;
  logic [1:0]                   delay = 2'h0;
  logic [15:0]                  erase_count;
  logic [7:0]                   last_block;
  logic                         bad_block;
  int                           passed_count = 0;
  logic [15:0]                  rnd = 16'h0045;
  logic [15:0]                  blk;
  logic                         bad;
  int                           failures = 0;
  int                           checked = 0;

  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) if (passed_on_o === 1'b1) passed_count <= passed_count + 1;

  flash_command_handler uut (.clock_i(clock_i), .resetn_i(resetn_i), .frame_info_i(frame_info_i),
    .frame_start_i(frame_start_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_last_i(byte_last_i),
    .byte_ready_o(byte_ready_o), .explicit_mode_i(explicit_mode_i), .erase_valid_o(erase_valid_o),
    .erase_block_o(erase_block_o), .erase_done_i(erase_done_i), .reply_valid_o(reply_valid_o),
    .reply_header_o(reply_header_o), .reply_route_o(reply_route_o), .reply_ready_i(reply_ready_i),
    .passed_on_o(passed_on_o));
  flash_erase_memory_model mem (.clock_i(clock_i), .resetn_i(resetn_i), .erase_valid_i(erase_valid_o),
    .erase_block_i(erase_block_o), .delay_i(delay), .erase_done_o(erase_done_i), .erase_count_o(erase_count),
    .last_block_o(last_block), .bad_block_o(bad_block));

  // ==========
  // Checking and closing
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic flash_cmd_pkg::frame_info_t info(input logic [7:0] src, input logic bc, input logic udp);
    return '{8'h11, 16'h0023, 8'he6, src, bc, udp, udp ? 16'h0bee : 16'h0000};
  endfunction
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang(input string what);
    failures++;
    $display("mismatch %s expected done seen timeout", what);
    test_done;
  endtask

  // ==========
  // One request frame and its reply
  task automatic run(input string name, input flash_cmd_pkg::frame_info_t fi, input logic mode,
                     input flash_cmd_pkg::header_t h, input logic rep, input flash_cmd_pkg::header_t eh,
                     input logic [15:0] n_erase);
    logic [15:0] base;
    logic        rx;
    int          n;
    base = erase_count;
    rx = !fi.from_udp && (fi.src_endpoint == 8'he6 || mode);
    frame_info_i = fi;
    explicit_mode_i = mode;
    frame_start_i = 1'b1;
    @(posedge clock_i);
    #5 frame_start_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      byte_valid_i = 1'b1;
      byte_i = h[63-8*i -: 8];
      byte_last_i = (i == 7);
      n = 0;
      do begin @(posedge clock_i); n++; end while (byte_ready_o !== 1'b1 && n < 50);
      if (n == 50) hang(name);
      #5;
    end
    byte_valid_i = 1'b0;
    byte_last_i = 1'b0;
    if (rep) begin
      n = 0;
      do begin @(posedge clock_i); n++; end while (reply_valid_o !== 1'b1 && n < 4000);
      if (n == 4000) hang(name);
      check({name, " header"}, reply_header_o, eh);
      check({name, " route"}, reply_route_o, {fi.src_endpoint, rx, fi.from_udp});
      #5 reply_ready_i = 1'b1;
      @(posedge clock_i);
      #5 reply_ready_i = 1'b0;
    end else begin
      repeat (30) begin
        @(posedge clock_i);
        check({name, " silent"}, reply_valid_o, 1'b0);
      end
      #5;
    end
    check({name, " erases"}, erase_count - base, n_erase);
    $display("test %s done", name);
  endtask

  // ==========
  // Scenarios
  initial begin
    flash_cmd_pkg::frame_info_t fi;
    flash_cmd_pkg::header_t     geo;
    flash_cmd_pkg::header_t     geo_rep;
    geo = '{8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000};
    geo_rep = '{flash_cmd_pkg::CMD_GEOMETRY_REPLY, 8'h00, 16'h00a0, 16'h1000, 16'h0000};
    repeat (8) @(posedge clock_i);
    #5 resetn_i = 1'b1;
    run("geometry e6", info(8'he6, 1'b0, 1'b0), 1'b0, geo, 1'b1, geo_rep, 16'h0);
    run("geometry mode", info(8'h10, 1'b0, 1'b0), 1'b1, geo, 1'b1, geo_rep, 16'h0);
    run("geometry plain", info(8'h10, 1'b0, 1'b0), 1'b0, geo, 1'b1, geo_rep, 16'h0);
    run("geometry udp", info(8'he6, 1'b0, 1'b1), 1'b1, geo, 1'b1, geo_rep, 16'h0);
    run("geometry bcast", info(8'h10, 1'b1, 1'b0), 1'b0, geo, 1'b0, geo, 16'h0);
    fi = info(8'h10, 1'b0, 1'b0);
    fi.frame_type = 8'h10;
    run("bad type", fi, 1'b0, geo, 1'b0, geo, 16'h0);
    fi = info(8'h10, 1'b0, 1'b0);
    fi.cluster = 16'h0032;
    run("bad cluster", fi, 1'b0, geo, 1'b0, geo, 16'h0);
    fi = info(8'h10, 1'b0, 1'b0);
    fi.dest_endpoint = 8'he7;
    run("bad endpoint", fi, 1'b0, geo, 1'b0, geo, 16'h0);
    fi = info(8'h10, 1'b0, 1'b1);
    fi.udp_port = 16'hee0b;
    run("bad port", fi, 1'b0, geo, 1'b0, geo, 16'h0);
    // Three byte erase header must be dropped
    frame_info_i = info(8'h20, 1'b0, 1'b0);
    frame_start_i = 1'b1;
    @(posedge clock_i);
    #5 frame_start_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      byte_valid_i = 1'b1;
      byte_i = 8'h01;
      byte_last_i = (i == 2);
      @(posedge clock_i);
      #5;
    end
    byte_valid_i = 1'b0;
    byte_last_i = 1'b0;
    repeat (30) begin
      @(posedge clock_i);
      check("short silent", {reply_valid_o, erase_valid_o}, 2'b00);
    end
    #5;
    $display("test short frame done");
    delay = 2'h2;
    run("erase 42", info(8'h20, 1'b0, 1'b0), 1'b0, '{8'h01, 8'h00, 16'h002a, 16'h0000, 16'h1000}, 1'b1,
        '{8'h81, 8'h00, 16'h002a, 16'h0000, 16'h0000}, 16'h1);
    check("erased block", last_block, 8'h2a);
    run("erase 159", info(8'h20, 1'b0, 1'b0), 1'b0, '{8'h01, 8'h00, 16'h009f, 16'h0000, 16'h1000}, 1'b1,
        '{8'h81, 8'h00, 16'h009f, 16'h0000, 16'h0000}, 16'h1);
    run("erase 160", info(8'h20, 1'b0, 1'b0), 1'b0, '{8'h01, 8'h00, 16'h00a0, 16'h0000, 16'h1000}, 1'b1,
        '{8'h81, 8'h01, 16'h00a0, 16'h0000, 16'h0000}, 16'h0);
    delay = 2'h0;
    run("erase all", info(8'he6, 1'b0, 1'b0), 1'b0, '{8'h01, 8'h00, 16'h0000, 16'h0000, 16'h0000}, 1'b1,
        '{8'h81, 8'h00, 16'h0000, 16'h0000, 16'h0000}, 16'h00a0);
    run("erase bcast", info(8'h20, 1'b1, 1'b0), 1'b0, '{8'h01, 8'h00, 16'h0003, 16'h0000, 16'h1000}, 1'b0,
        geo, 16'h1);
    check("passed quiet", passed_count, 0);
    run("unknown code", info(8'h20, 1'b0, 1'b0), 1'b0, '{8'h05, 8'h00, 16'h0102, 16'h0304, 16'h0000}, 1'b1,
        '{8'h85, 8'h01, 16'h0102, 16'h0304, 16'h0000}, 16'h0);
    check("passed on", passed_count, 1);
    repeat (6) begin
      rnd = lfsr(rnd);
      blk = {8'h00, rnd[7:0]};
      bad = blk > 16'h009f;
      delay = rnd[11:10];
      run("random erase", info(rnd[15:8], 1'b0, rnd[12]), rnd[9], '{8'h01, 8'h00, blk, 16'h0000, 16'h1000},
          1'b1, '{8'h81, {7'h00, bad}, blk, 16'h0000, 16'h0000}, {15'h0, !bad});
      if (!bad) check("random block", last_block, blk[7:0]);
    end
    check("block range", bad_block, 1'b0);
    test_done;
  end
endmodule
